// *** src/otu_pkg.sv ***
// constants and types shared by the on-chip trace unit
// Behaviour
// - eight-entry capture buffer for addresses or data
// - two 16-bit comparators, optional direction qualify
// - opcode tracking triggers only on real execution, except in event modes
// - inside and outside range comparisons supported
// - comparators blind during background debug accesses
// - A compares address; B address or data
// - write data bus only when qualify=1, dir=0
// - match breaks, stores data, begins or ends
// - count of valid words; early halt shifts once
// - read high then low; low read shifts
// - event modes store bytes, low read shifts
// - trigger and next two cycles not captured
// - end trigger change-of-flow stored as last
// - disarmed low read pushes last opcode fetch address
// - taken conditional branch stores source; always/never nothing
// - indirect jump or call stores index destination
// - interrupt, returns store destination address
// - tag marks at fetch, acts on execution except in event modes
package otu_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int CTRL_W = 16;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_CMP_A = 8'h00;
  localparam logic [7:0] OFF_CMP_B = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_BUF_HIGH = 8'h10;
  localparam logic [7:0] OFF_BUF_LOW = 8'h14;

  // ****************************************************************
  // control and status fields
  // ****************************************************************
  localparam int CTRL_ARM = 0;
  localparam int CTRL_TAG = 1;
  localparam int CTRL_A_QEN = 2;
  localparam int CTRL_A_SEL = 3;
  localparam int CTRL_B_QEN = 4;
  localparam int CTRL_B_SEL = 5;
  localparam int CTRL_END_TRACE = 6;
  localparam int CTRL_BRK = 7;
  localparam int CTRL_MODE_LSB = 8;
  localparam int MODE_W = 3;
  localparam int STAT_ARMED = 4;
  localparam int STAT_TAG = 5;

  localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] CMP_RST = 16'h0000;
  localparam logic [1:0] COF_SKIP = 2'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [MODE_W-1:0] {
    MODE_A_ONLY,
    MODE_A_OR_B,
    MODE_A_AND_DATA,
    MODE_INSIDE,
    MODE_OUTSIDE,
    MODE_EVT_A,
    MODE_EVT_A_DATA
  } otu_mode_t;

  typedef enum logic [2:0] {
    COF_NONE,
    COF_COND_TAKEN,
    COF_BRANCH_ALWAYS,
    COF_BRANCH_NEVER,
    COF_INDIRECT,
    COF_DEST
  } otu_cof_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_STORE
  } otu_state_t;

endpackage

// *** src/otu_top.sv ***
// on-chip trace unit: comparators, trigger logic, capture buffer, AHB-Lite registers
`timescale 1ns/100ps
module otu_top #(
  parameter int FIFO_DEPTH = otu_pkg::FIFO_DEPTH
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic cpu_valid_in,
  input wire logic [15:0] cpu_addr_in,
  input wire logic cpu_rw_in,
  input wire logic [7:0] cpu_wdata_in,
  input wire logic [7:0] cpu_rdata_in,
  input wire logic cpu_opfetch_in,
  input wire logic cpu_exec_in,
  input wire logic [15:0] cpu_exec_addr_in,
  input wire logic cpu_flush_in,
  input wire logic [2:0] cpu_cof_kind_in,
  input wire logic [15:0] cpu_cof_src_in,
  input wire logic [15:0] cpu_cof_dst_in,
  input wire logic [15:0] cpu_hx_in,
  input wire logic background_debug_port_active_in,
  output logic cpu_break_out,
  output logic trace_armed_out
);

  // the count needs one code more than the depth to tell full from empty
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // ****************************************************************
  // bus slave
  // ****************************************************************
  // read data is captured at the address edge, so a read in the data phase
  // of a write still returns the old register value
  logic ph_valid_q, ph_valid_d;
  logic ph_write_q, ph_write_d;
  logic [7:0] ph_off_q, ph_off_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic acc;
  logic rd_low;
  logic wr_en;

  // core state, declared here so the read mux can see it
  logic [15:0] cmp_a_q, cmp_a_d;
  logic [15:0] cmp_b_q, cmp_b_d;
  logic [otu_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [15:0] fifo_q [FIFO_DEPTH];
  logic [15:0] fifo_d [FIFO_DEPTH];
  logic [CNT_W-1:0] cnt_q, cnt_d;
  otu_pkg::otu_state_t state_q, state_d;
  logic [1:0] skip_q, skip_d;
  logic [15:0] tag_addr_q, tag_addr_d;
  logic tag_v_q, tag_v_d;
  logic [15:0] last_fetch_q, last_fetch_d;
  logic brk_q, brk_d;

  // zero wait states: the request is taken in the address phase
  assign acc = hsel_in && hready_in && htrans_in[1];
  assign rd_low = acc && !hwrite_in && (haddr_in[7:0] == otu_pkg::OFF_BUF_LOW);
  assign wr_en = ph_valid_q && ph_write_q;

  always_comb begin
    ph_valid_d = acc;
    ph_write_d = acc && hwrite_in;
    ph_off_d = acc ? haddr_in[7:0] : ph_off_q;
    hrdata_d = hrdata_q;
    if (acc && !hwrite_in) begin
      unique case (haddr_in[7:0])
        otu_pkg::OFF_CMP_A: hrdata_d = {16'h0000, cmp_a_q};
        otu_pkg::OFF_CMP_B: hrdata_d = {16'h0000, cmp_b_q};
        otu_pkg::OFF_CTRL: hrdata_d = {16'h0000, ctrl_q};
        otu_pkg::OFF_STATUS: begin
          hrdata_d = 32'h0000_0000;
          hrdata_d[CNT_W-1:0] = cnt_q;
          hrdata_d[otu_pkg::STAT_ARMED] = ctrl_q[otu_pkg::CTRL_ARM];
          hrdata_d[otu_pkg::STAT_TAG] = tag_v_q;
        end
        otu_pkg::OFF_BUF_HIGH: hrdata_d = {24'h000000, fifo_q[0][15:8]};
        otu_pkg::OFF_BUF_LOW: hrdata_d = {24'h000000, fifo_q[0][7:0]};
        default: hrdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_off_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      ph_valid_q <= ph_valid_d;
      ph_write_q <= ph_write_d;
      ph_off_q <= ph_off_d;
      hrdata_q <= hrdata_d;
    end
  end

  // no wait states and no error response: every access completes at once
  assign hrdata_out = hrdata_q;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  // ****************************************************************
  // comparators
  // ****************************************************************
  otu_pkg::otu_mode_t mode;
  otu_pkg::otu_cof_t cof_kind;
  logic cmp_live, dir_ok_a, dir_ok_b;
  logic hit_a, hit_b_addr, hit_b_data, in_range;
  logic [7:0] b_data;
  logic raw_match, event_mode, trig;
  logic cof_v;
  logic [15:0] cof_addr;

  assign mode = otu_pkg::otu_mode_t'(ctrl_q[otu_pkg::CTRL_MODE_LSB +: otu_pkg::MODE_W]);
  assign cof_kind = otu_pkg::otu_cof_t'(cpu_cof_kind_in);
  // debugger cycles must never look like program activity
  assign cmp_live = cpu_valid_in && !background_debug_port_active_in;
  assign dir_ok_a = !ctrl_q[otu_pkg::CTRL_A_QEN] || (cpu_rw_in == ctrl_q[otu_pkg::CTRL_A_SEL]);
  assign dir_ok_b = !ctrl_q[otu_pkg::CTRL_B_QEN] || (cpu_rw_in == ctrl_q[otu_pkg::CTRL_B_SEL]);
  // the write bus is only valid for qualified write cycles
  // only the A direction bits pick the bus, the B bits only qualify B
  assign b_data = (ctrl_q[otu_pkg::CTRL_A_QEN] && !ctrl_q[otu_pkg::CTRL_A_SEL]) ?
                  cpu_wdata_in : cpu_rdata_in;
  assign hit_a = cmp_live && dir_ok_a && (cpu_addr_in == cmp_a_q);
  assign hit_b_addr = cmp_live && dir_ok_b && (cpu_addr_in == cmp_b_q);
  assign hit_b_data = cmp_live && dir_ok_b && (b_data == cmp_b_q[7:0]);
  // range bounds are inclusive at both ends, A is the low bound
  assign in_range = (cpu_addr_in >= cmp_a_q) && (cpu_addr_in <= cmp_b_q);
  assign event_mode = (mode == otu_pkg::MODE_EVT_A) || (mode == otu_pkg::MODE_EVT_A_DATA);

  always_comb begin
    raw_match = 1'b0;
    unique case (mode)
      otu_pkg::MODE_A_ONLY: raw_match = hit_a;
      otu_pkg::MODE_A_OR_B: raw_match = hit_a || hit_b_addr;
      otu_pkg::MODE_A_AND_DATA: raw_match = hit_a && hit_b_data;
      otu_pkg::MODE_INSIDE: raw_match = cmp_live && dir_ok_a && in_range;
      otu_pkg::MODE_OUTSIDE: raw_match = cmp_live && dir_ok_a && !in_range;
      otu_pkg::MODE_EVT_A: raw_match = hit_a;
      otu_pkg::MODE_EVT_A_DATA: raw_match = hit_a && hit_b_data;
      default: raw_match = 1'b0;
    endcase
  end

  // tag acts when the marked opcode executes, force acts on the match itself;
  // event modes capture bus data, so they always act on the matching cycle
  assign trig = (ctrl_q[otu_pkg::CTRL_TAG] && !event_mode) ?
                (tag_v_q && cpu_exec_in && (cpu_exec_addr_in == tag_addr_q)) :
                raw_match;

  // ****************************************************************
  // change-of-flow selection
  // ****************************************************************
  always_comb begin
    cof_v = 1'b0;
    cof_addr = 16'h0000;
    unique case (cof_kind)
      otu_pkg::COF_COND_TAKEN: begin
        cof_v = 1'b1;
        cof_addr = cpu_cof_src_in;
      end
      otu_pkg::COF_INDIRECT: begin
        cof_v = 1'b1;
        cof_addr = cpu_hx_in;
      end
      otu_pkg::COF_DEST: begin
        cof_v = 1'b1;
        cof_addr = cpu_cof_dst_in;
      end
      // unconditional branches carry no flow information
      otu_pkg::COF_BRANCH_ALWAYS: cof_v = 1'b0;
      otu_pkg::COF_BRANCH_NEVER: cof_v = 1'b0;
      otu_pkg::COF_NONE: cof_v = 1'b0;
      // codes 6 and 7 carry no flow change
      default: cof_v = 1'b0;
    endcase
  end

  // ****************************************************************
  // trigger sequencing and capture buffer
  // ****************************************************************
  logic push, pop, halt_shift;
  logic [15:0] push_data;
  logic disarm;

  always_comb begin
    cmp_a_d = cmp_a_q;
    cmp_b_d = cmp_b_q;
    ctrl_d = ctrl_q;
    state_d = state_q;
    skip_d = skip_q;
    cnt_d = cnt_q;
    tag_addr_d = tag_addr_q;
    tag_v_d = tag_v_q;
    last_fetch_d = last_fetch_q;
    brk_d = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    halt_shift = 1'b0;
    push_data = 16'h0000;
    disarm = 1'b0;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      fifo_d[i] = fifo_q[i];
    end

    if (cmp_live && cpu_opfetch_in) begin
      last_fetch_d = cpu_addr_in;
    end

    // tag is set at fetch and dropped if the queue is flushed
    if (cpu_flush_in) begin
      tag_v_d = 1'b0;
    end else if (trig && ctrl_q[otu_pkg::CTRL_TAG]) begin
      tag_v_d = 1'b0;
    end
    // one tag latch only: a newer marked fetch replaces a pending one
    if (ctrl_q[otu_pkg::CTRL_TAG] && raw_match && cpu_opfetch_in) begin
      tag_v_d = 1'b1;
      tag_addr_d = cpu_addr_in;
    end

    unique case (state_q)
      otu_pkg::ST_IDLE: begin
        // disarmed: every low-byte read feeds the profiling stream
        if (rd_low) begin
          push = 1'b1;
          push_data = last_fetch_q;
        end
      end
      otu_pkg::ST_WAIT: begin
        if (trig) begin
          if (ctrl_q[otu_pkg::CTRL_BRK]) begin
            brk_d = 1'b1;
            disarm = 1'b1;
          end else if (event_mode) begin
            // event modes store every matching byte, no pipe delay applies
            push = 1'b1;
            push_data = {8'h00, b_data};
          end else begin
            // trigger cycle and the two after it are lost in the input pipe
            state_d = otu_pkg::ST_STORE;
            skip_d = otu_pkg::COF_SKIP;
          end
        end
      end
      otu_pkg::ST_STORE: begin
        if (skip_q != 2'h0) begin
          // only real bus cycles age the input pipe, idle clocks do not
          if (cpu_valid_in) begin
            skip_d = skip_q - 2'h1;
          end
        end else if (cof_v) begin
          push = 1'b1;
          push_data = cof_addr;
        end
        // end trace: a flow change on the trigger itself is the last entry
        if (ctrl_q[otu_pkg::CTRL_END_TRACE] && trig) begin
          disarm = 1'b1;
          if (cof_v) begin
            push = 1'b1;
            push_data = cof_addr;
          end
        end
      end
    endcase

    if (rd_low && state_q != otu_pkg::ST_IDLE) begin
      pop = 1'b1;
    end

    // push and pop together count as a push: one shift drops the port word
    // and brings in the new one; the count saturates so profiling never wraps
    if (push) begin
      if (cnt_q != CNT_FULL) begin
        cnt_d = cnt_q + CNT_ONE;
      end
      if (state_q != otu_pkg::ST_IDLE && cnt_q == CNT_FULL - CNT_ONE) begin
        disarm = 1'b1;
      end
    end else if (pop && cnt_q != '0) begin
      cnt_d = cnt_q - CNT_ONE;
    end

    if (disarm) begin
      ctrl_d[otu_pkg::CTRL_ARM] = 1'b0;
      state_d = otu_pkg::ST_IDLE;
    end

    // a software write to the control word beats a hardware disarm in the
    // same cycle, so the written ARM bit is kept while the state still drops to ST_IDLE
    if (wr_en) begin
      unique case (ph_off_q)
        otu_pkg::OFF_CMP_A: cmp_a_d = hwdata_in[15:0];
        otu_pkg::OFF_CMP_B: cmp_b_d = hwdata_in[15:0];
        otu_pkg::OFF_CTRL: begin
          ctrl_d = hwdata_in[otu_pkg::CTRL_W-1:0];
          if (hwdata_in[otu_pkg::CTRL_ARM] && !ctrl_q[otu_pkg::CTRL_ARM]) begin
            cnt_d = '0;
            skip_d = 2'h0;
            state_d = hwdata_in[otu_pkg::CTRL_END_TRACE] && !hwdata_in[otu_pkg::CTRL_BRK] ?
                      otu_pkg::ST_STORE : otu_pkg::ST_WAIT;
          end else if (!hwdata_in[otu_pkg::CTRL_ARM] && ctrl_q[otu_pkg::CTRL_ARM]) begin
            // manual halt before full leaves one extra shift behind
            // the halt leaves the count unchanged so the host can work out its dummy reads
            state_d = otu_pkg::ST_IDLE;
            halt_shift = (cnt_q != CNT_FULL);
          end
        end
        default: begin
        end
      endcase
    end

    // single shift path: new entry enters at the top, the port reads entry 0
    if (push || pop || halt_shift) begin
      for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
        fifo_d[i] = fifo_q[i+1];
      end
      fifo_d[FIFO_DEPTH-1] = push ? push_data : 16'h0000;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      // only reset clears the buffer; arming keeps the old words in place
      cmp_a_q <= otu_pkg::CMP_RST;
      cmp_b_q <= otu_pkg::CMP_RST;
      ctrl_q <= otu_pkg::CTRL_RST;
      state_q <= otu_pkg::ST_IDLE;
      skip_q <= 2'h0;
      cnt_q <= '0;
      tag_addr_q <= 16'h0000;
      tag_v_q <= 1'b0;
      last_fetch_q <= 16'h0000;
      brk_q <= 1'b0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_q[i] <= 16'h0000;
      end
    end else begin
      cmp_a_q <= cmp_a_d;
      cmp_b_q <= cmp_b_d;
      ctrl_q <= ctrl_d;
      state_q <= state_d;
      skip_q <= skip_d;
      cnt_q <= cnt_d;
      tag_addr_q <= tag_addr_d;
      tag_v_q <= tag_v_d;
      last_fetch_q <= last_fetch_d;
      brk_q <= brk_d;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_q[i] <= fifo_d[i];
      end
    end
  end

  // registered break gives the core a clean one-cycle request
  assign cpu_break_out = brk_q;
  assign trace_armed_out = ctrl_q[otu_pkg::CTRL_ARM];

endmodule

// *** tb/otu_cpu_model.sv ***
// cpu core bus model driving the trace unit's cpu side
`timescale 1ns/100ps
module otu_cpu_model (
  input logic clock_in,
  output logic valid_out,
  output logic [15:0] addr_out,
  output logic rw_out,
  output logic [7:0] wdata_out,
  output logic [7:0] rdata_out,
  output logic fetch_out,
  output logic exec_out,
  output logic [15:0] exec_addr_out,
  output logic flush_out,
  output logic [2:0] cof_kind_out,
  output logic [15:0] cof_src_out,
  output logic [15:0] cof_dst_out,
  output logic [15:0] hx_out
);
  initial begin
    {flush_out, exec_out, fetch_out, valid_out, rw_out} = 5'h01;
    cof_kind_out = 3'h0;
    {addr_out, exec_addr_out, cof_src_out, cof_dst_out, hx_out} = 80'h0;
    {wdata_out, rdata_out} = 16'h0;
  end
  // one cycle; afterwards the buses show inverted values so a stale value never matches
  task automatic cyc(input logic [15:0] a, input logic rd, input logic [7:0] wd, input logic [7:0] rdd,
    input logic [3:0] fl, input logic [2:0] k, input logic [15:0] cv);
    @(posedge clock_in);
    {flush_out, exec_out, fetch_out, valid_out} <= fl;
    addr_out <= a;
    exec_addr_out <= a;
    rw_out <= rd;
    wdata_out <= wd;
    rdata_out <= rdd;
    cof_kind_out <= k;
    cof_src_out <= cv;
    hx_out <= cv + 16'h0001;
    cof_dst_out <= cv + 16'h0002;
    @(posedge clock_in);
    {flush_out, exec_out, fetch_out, valid_out} <= 4'h0;
    cof_kind_out <= 3'h0;
    addr_out <= ~a;
    exec_addr_out <= ~a;
    wdata_out <= ~wd;
    rdata_out <= ~rdd;
    {cof_src_out, cof_dst_out, hx_out} <= {~cv, ~cv, ~cv};
  endtask
endmodule

// *** tb/otu_monitor.sv ***
// checker for the trace unit register bus and break output
`timescale 1ns/100ps
module otu_monitor #(
  parameter int FIFO_DEPTH = 8
) (
  input logic clock_in,
  input logic reset_in,
  input logic hsel_in,
  input logic [31:0] haddr_in,
  input logic [1:0] htrans_in,
  input logic hwrite_in,
  input logic [31:0] hwdata_in,
  input logic hready_in,
  input logic [31:0] hrdata_out,
  input logic hreadyout_out,
  input logic hresp_out,
  input logic cpu_valid_in,
  input logic cpu_exec_in,
  input logic background_debug_port_active_in,
  input logic cpu_break_out,
  input logic trace_armed_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  logic rd_take;
  logic wr_take;
  logic cmp_live;
  assign rd_take = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
  assign wr_take = hsel_in && hready_in && htrans_in[1] && hwrite_in;
  // exec may fire a pending tag even while the debug port is busy
  assign cmp_live = (cpu_valid_in && !background_debug_port_active_in) || cpu_exec_in;
  // ****************************************************************
  // properties
  // ****************************************************************
  sequence s_ctrl_wr;
    wr_take && haddr_in[7:0] == 8'h08 ##1 1'b1;
  endsequence
  sequence s_stat_rd;
    rd_take && haddr_in[7:0] == 8'h0c;
  endsequence
  property p_ok_resp;
    hreadyout_out && !hresp_out;
  endproperty
  a_ok_resp: assert property (p_ok_resp) else $error("bus response not ready okay");
  property p_reset;
    disable iff (1'b0) reset_in |=> hrdata_out == 32'h0 && !trace_armed_out && !cpu_break_out;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_break_pulse;
    cpu_break_out |=> !cpu_break_out;
  endproperty
  a_break_pulse: assert property (p_break_pulse) else $error("break longer than one cycle");
  property p_break_armed;
    $rose(cpu_break_out) |-> $past(trace_armed_out) || $past(trace_armed_out, 2);
  endproperty
  a_break_armed: assert property (p_break_armed) else $error("break while disarmed");
  property p_break_disarms;
    cpu_break_out |-> ##[0:1] !trace_armed_out;
  endproperty
  a_break_disarms: assert property (p_break_disarms) else $error("break left unit armed");
  property p_blind;
    $rose(cpu_break_out) |-> $past(cmp_live) || $past(cmp_live, 2);
  endproperty
  a_blind: assert property (p_blind) else $error("break without live cpu cycle");
  property p_arm_write;
    s_ctrl_wr |=> trace_armed_out == $past(hwdata_in[0]);
  endproperty
  a_arm_write: assert property (p_arm_write) else $error("arm bit not written");
  property p_status_rd;
    s_stat_rd |=> hrdata_out[4] == $past(trace_armed_out);
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status armed bit wrong");
  property p_unmapped;
    rd_take && haddr_in[7:0] >= 8'h18 |=> hrdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rdata_stands;
    $changed(hrdata_out) |-> $past(rd_take) || $past(reset_in);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands) else $error("read data changed without read");
endmodule
bind otu_top otu_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (.clock_in, .reset_in, .hsel_in, .haddr_in,
  .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .cpu_valid_in,
  .cpu_exec_in, .background_debug_port_active_in, .cpu_break_out, .trace_armed_out);

// *** tb/tb_otu_top.sv ***
// self-checking bench for the on-chip trace unit
`timescale 1ns/100ps
module tb_otu_top;
  logic clock_in, reset_in, hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, rv;
  logic [1:0] htrans_in;
  logic [2:0] hsize_in, cpu_cof_kind_in;
  logic cpu_valid_in, cpu_rw_in, cpu_opfetch_in, cpu_exec_in, cpu_flush_in, background_debug_port_active_in;
  logic cpu_break_out, trace_armed_out;
  logic [7:0] cpu_wdata_in, cpu_rdata_in;
  logic [15:0] cpu_addr_in, cpu_exec_addr_in, cpu_cof_src_in, cpu_cof_dst_in, cpu_hx_in;
  int error_cnt = 0, compares = 0, brk_cnt = 0, n;
  assign hready_in = hreadyout_out;
  otu_top uut (.clock_in, .reset_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in,
    .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .cpu_valid_in, .cpu_addr_in, .cpu_rw_in,
    .cpu_wdata_in, .cpu_rdata_in, .cpu_opfetch_in, .cpu_exec_in, .cpu_exec_addr_in, .cpu_flush_in,
    .cpu_cof_kind_in, .cpu_cof_src_in, .cpu_cof_dst_in, .cpu_hx_in, .background_debug_port_active_in,
    .cpu_break_out, .trace_armed_out);
  otu_cpu_model cpu (.clock_in, .valid_out(cpu_valid_in), .addr_out(cpu_addr_in), .rw_out(cpu_rw_in),
    .wdata_out(cpu_wdata_in), .rdata_out(cpu_rdata_in), .fetch_out(cpu_opfetch_in), .exec_out(cpu_exec_in),
    .exec_addr_out(cpu_exec_addr_in), .flush_out(cpu_flush_in), .cof_kind_out(cpu_cof_kind_in),
    .cof_src_out(cpu_cof_src_in), .cof_dst_out(cpu_cof_dst_in), .hx_out(cpu_hx_in));
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  always @(posedge clock_in) if (cpu_break_out === 1'b1) brk_cnt <= brk_cnt + 1;
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= {24'h0, a};
    hwrite_in <= w;
    do @(posedge clock_in); while (hready_in !== 1'b1);
    htrans_in <= 2'h0;
    hsel_in <= 1'b0;
    hwdata_in <= wd;
    do @(posedge clock_in); while (hready_in !== 1'b1);
    rv = hrdata_out;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  task automatic cf(input logic [15:0] a, input logic [2:0] k, input logic [15:0] cv);
    cpu.cyc(a, 1'b1, 8'h00, 8'h00, 4'h1, k, cv);
  endtask
  task automatic brk(input logic [15:0] c, input logic [15:0] a, input logic r, input logic b, input logic e);
    ahb(1'b1, 8'h08, {16'h0, c});
    n = brk_cnt;
    background_debug_port_active_in <= b;
    cpu.cyc(a, r, 8'h00, 8'h00, 4'h1, 3'h0, 16'h0);
    repeat (3) @(posedge clock_in);
    background_debug_port_active_in <= 1'b0;
    chk(brk_cnt - n, {31'h0, e});
  endtask
  initial begin
    #200000;
    error_cnt++;
    wrap_up;
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    reset_in = 1'b1;
    hsel_in = 1'b0;
    htrans_in = 2'h0;
    haddr_in = 32'h0;
    hwrite_in = 1'b0;
    hsize_in = 3'h2;
    hwdata_in = 32'h0;
    background_debug_port_active_in = 1'b0;
    repeat (6) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(8'h0c, 32'h0);
    rd(8'h18, 32'h0);
    ahb(1'b1, 8'h00, 32'h1234);
    ahb(1'b1, 8'h04, 32'h1240);
    rd(8'h00, 32'h1234);
    for (int i = 0; i < 8; i++) begin
      cpu.cyc(16'h2a10 + 16'(i), 1'b1, 8'h00, 8'h00, 4'h3, 3'h0, 16'h0);
      ahb(1'b0, 8'h14, 32'h0);
    end
    rd(8'h0c, 32'h8);
    rd(8'h10, 32'h2a);
    rd(8'h10, 32'h2a);
    rd(8'h14, 32'h10);
    rd(8'h14, 32'h11);
    brk(16'h0081, 16'h1234, 1'b1, 1'b1, 1'b0);
    brk(16'h0081, 16'h1234, 1'b1, 1'b0, 1'b1);
    brk(16'h0081, 16'h1235, 1'b1, 1'b0, 1'b0);
    brk(16'h008d, 16'h1234, 1'b0, 1'b0, 1'b0);
    brk(16'h008d, 16'h1234, 1'b1, 1'b0, 1'b1);
    brk(16'h0181, 16'h1240, 1'b1, 1'b0, 1'b1);
    brk(16'h0381, 16'h1238, 1'b1, 1'b0, 1'b1);
    brk(16'h0381, 16'h1230, 1'b1, 1'b0, 1'b0);
    brk(16'h0481, 16'h1238, 1'b1, 1'b0, 1'b0);
    brk(16'h0481, 16'h1241, 1'b1, 1'b0, 1'b1);
    ahb(1'b1, 8'h08, 32'h0083);
    n = brk_cnt;
    cpu.cyc(16'h1234, 1'b1, 8'h00, 8'h00, 4'h3, 3'h0, 16'h0);
    cpu.cyc(16'h0000, 1'b1, 8'h00, 8'h00, 4'h8, 3'h0, 16'h0);
    cpu.cyc(16'h1234, 1'b1, 8'h00, 8'h00, 4'h4, 3'h0, 16'h0);
    repeat (3) @(posedge clock_in);
    chk(brk_cnt - n, 32'h0);
    cpu.cyc(16'h1234, 1'b1, 8'h00, 8'h00, 4'h3, 3'h0, 16'h0);
    cpu.cyc(16'h1234, 1'b1, 8'h00, 8'h00, 4'h4, 3'h0, 16'h0);
    repeat (3) @(posedge clock_in);
    chk(brk_cnt - n, 32'h1);
    ahb(1'b1, 8'h08, 32'h0001);
    rd(8'h0c, 32'h10);
    cf(16'h1234, 3'h1, 16'h5010);
    cf(16'h3000, 3'h5, 16'h5020);
    cf(16'h3001, 3'h4, 16'h5030);
    cf(16'h3002, 3'h1, 16'h6010);
    cf(16'h3003, 3'h2, 16'h6070);
    cf(16'h3004, 3'h3, 16'h6080);
    cf(16'h3005, 3'h4, 16'h6020);
    cf(16'h3006, 3'h5, 16'h6030);
    rd(8'h0c, 32'h13);
    ahb(1'b1, 8'h08, 32'h0);
    rd(8'h0c, 32'h03);
    repeat (4) ahb(1'b0, 8'h14, 32'h0);
    rd(8'h10, 32'h60);
    rd(8'h14, 32'h10);
    rd(8'h10, 32'h60);
    rd(8'h14, 32'h21);
    rd(8'h10, 32'h60);
    rd(8'h14, 32'h32);
    ahb(1'b1, 8'h08, 32'h0041);
    cf(16'h3000, 3'h1, 16'h7010);
    cf(16'h1234, 3'h5, 16'h7020);
    cf(16'h3001, 3'h1, 16'h7030);
    rd(8'h0c, 32'h02);
    repeat (6) ahb(1'b0, 8'h14, 32'h0);
    rd(8'h10, 32'h70);
    rd(8'h14, 32'h10);
    rd(8'h10, 32'h70);
    rd(8'h14, 32'h22);
    ahb(1'b1, 8'h08, 32'h0501);
    for (int i = 0; i < 8; i++) cpu.cyc(16'h1234, 1'b1, 8'h00, 8'h40 + 8'(i), 4'h1, 3'h0, 16'h0);
    rd(8'h0c, 32'h08);
    rd(8'h10, 32'h0);
    for (int i = 0; i < 8; i++) rd(8'h14, 32'h40 + 32'(i));
    ahb(1'b1, 8'h04, 32'h00a5);
    ahb(1'b1, 8'h08, 32'h0605);
    cpu.cyc(16'h1234, 1'b0, 8'ha5, 8'h5a, 4'h1, 3'h0, 16'h0);
    cpu.cyc(16'h1234, 1'b0, 8'h5a, 8'ha5, 4'h1, 3'h0, 16'h0);
    rd(8'h0c, 32'h11);
    ahb(1'b1, 8'h08, 32'h0285);
    n = brk_cnt;
    cpu.cyc(16'h1234, 1'b0, 8'h5a, 8'ha5, 4'h1, 3'h0, 16'h0);
    repeat (3) @(posedge clock_in);
    chk(brk_cnt - n, 32'h0);
    cpu.cyc(16'h1234, 1'b0, 8'ha5, 8'h5a, 4'h1, 3'h0, 16'h0);
    repeat (3) @(posedge clock_in);
    chk(brk_cnt - n, 32'h1);
    brk(16'h0781, 16'h1234, 1'b1, 1'b0, 1'b0);
    wrap_up;
  end
endmodule
